// ===== hw/fos_core.sv
// Purpose: Offset-apply and terminal-force logic of the drive command path
// Assumes: Avalon-MM slave, word index addressing, 40 MHz clock
// Notes:   Five intelligent inputs, each mapped by an 8-bit function code
`timescale 1ns/1ps
`include "fos_defs.svh"
module fos_core #(
  parameter int N_IN = 5,
  parameter int FW   = 16
) (
  input  wire logic             i_core_clk,
  input  wire logic             i_arst_n,
  input  wire logic [N_IN-1:0]  i_term_in,
  input  wire logic [FW-1:0]    i_freq_setting,
  input  wire logic             i_motor_running,
  input  wire logic             i_motor_stopped,
  input  wire logic [3:0]       i_avs_address,
  input  wire logic             i_avs_read,
  input  wire logic             i_avs_write,
  input  wire logic [31:0]      i_avs_writedata,
  output logic [31:0]           o_avs_readdata,
  output logic                  o_avs_waitrequest,
  output logic [FW-1:0]         o_freq_out,
  output fos_pkg::fos_src_s     o_eff_src,
  output logic                  o_stop_req
);
  import fos_pkg::*;

  // Reset release through two flops
  logic rst_m_q, rst_n_q;
  always_ff @(posedge i_core_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      rst_m_q <= 1'b0;
      rst_n_q <= 1'b0;
    end
    else
    begin
      rst_m_q <= 1'b1;
      rst_n_q <= rst_m_q;
    end
  end

  // Terminal pins pass two flops before use
  logic [N_IN-1:0] sync1_q, sync2_q;
  always_ff @(posedge i_core_clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
    end
    else
    begin
      sync1_q <= i_term_in;
      sync2_q <= sync1_q;
    end
  end

  // Software settings
  logic [FW-1:0] offset_frequency_value_q, offset_frequency_value_d;
  logic          offset_direction_select_q, offset_direction_select_d;
  logic [7:0]    frequency_source_select_q, frequency_source_select_d;
  logic [7:0]    run_command_source_select_q, run_command_source_select_d;
  logic [7:0]    func_map_q [N_IN];
  logic [7:0]    func_map_d [N_IN];
  logic          ack_q, ack_d;
  logic [31:0]   rdata_q, rdata_d;

  // Function decode per input
  logic [N_IN-1:0] is_ofs, is_frc;
  genvar g;
  generate
    for (g = 0; g < N_IN; g++)
    begin : g_map
      assign is_ofs[g] = sync2_q[g] && (func_map_q[g] == `FOS_FUNC_OFFSET);
      assign is_frc[g] = sync2_q[g] && (func_map_q[g] == `FOS_FUNC_FORCE);
    end
  endgenerate
  logic offset_apply, terminal_source_force_input;
  assign offset_apply = |is_ofs;
  assign terminal_source_force_input = |is_frc;

  // Force state machine: applied force level only moves while motor is stopped
  fos_state_e state_q, state_d;
  logic       force_q, force_d;
  always_comb
  begin
    state_d = state_q;
    force_d = force_q;
    unique case (state_q)
      FOS_RUN:
        if (terminal_source_force_input != force_q)
        begin
          if (i_motor_running)
            state_d = FOS_STOPPING;
          else
            force_d = terminal_source_force_input;
        end
      FOS_STOPPING:
        if (i_motor_stopped)
          state_d = FOS_SWITCH;
      FOS_SWITCH:
      begin
        force_d = terminal_source_force_input;
        state_d = FOS_RUN;
      end
      default:
        state_d = FOS_RUN;
    endcase
  end

  // Register bus: one wait cycle, then ack; a write lands only on the edge
  // where waitrequest is seen low, so an abandoned request changes nothing
  always_comb
  begin
    offset_frequency_value_d    = offset_frequency_value_q;
    offset_direction_select_d   = offset_direction_select_q;
    frequency_source_select_d   = frequency_source_select_q;
    run_command_source_select_d = run_command_source_select_q;
    func_map_d = func_map_q;
    rdata_d    = rdata_q;
    ack_d      = 1'b0;
    if ((i_avs_read || i_avs_write) && !ack_q)
    begin
      ack_d   = 1'b1;
      rdata_d = '0;
      if (i_avs_read)
      begin
        unique case (i_avs_address)
          `FOS_OFS_OFFSET_VALUE: rdata_d[FW-1:0] = offset_frequency_value_q;
          `FOS_OFS_OFFSET_DIR:   rdata_d[0]      = offset_direction_select_q;
          `FOS_OFS_FREQ_SRC:     rdata_d[7:0]    = frequency_source_select_q;
          `FOS_OFS_RUN_SRC:      rdata_d[7:0]    = run_command_source_select_q;
          `FOS_OFS_INPUT_MAP:
            for (int k = 0; k < N_IN && k < 4; k++)
              rdata_d[8*k +: 8] = func_map_q[k];
          `FOS_OFS_INPUT_MAP_HI:   // Inputs beyond the fourth live in a second word
            for (int k = 4; k < N_IN && k < 8; k++)
              rdata_d[8*(k-4) +: 8] = func_map_q[k];
          `FOS_OFS_STATUS:
            rdata_d[3:0] = {o_stop_req, force_q, terminal_source_force_input, offset_apply};
          `FOS_OFS_FREQ_SET:     rdata_d[FW-1:0] = i_freq_setting;
          `FOS_OFS_FREQ_OUT:     rdata_d[FW-1:0] = o_freq_out;
          default:               rdata_d = '0;   // Unmapped reads zero
        endcase
      end
    end
    // Acked write: ack_q is high only in the cycle after this request was taken
    if (i_avs_write && ack_q)
    begin
      if (i_avs_address == `FOS_OFS_OFFSET_VALUE)
        offset_frequency_value_d = i_avs_writedata[FW-1:0];
      if (i_avs_address == `FOS_OFS_OFFSET_DIR)
        offset_direction_select_d = i_avs_writedata[0];
      if (i_avs_address == `FOS_OFS_FREQ_SRC)
        frequency_source_select_d = i_avs_writedata[7:0];
      if (i_avs_address == `FOS_OFS_RUN_SRC)
        run_command_source_select_d = i_avs_writedata[7:0];
      for (int k = 0; k < N_IN && k < 8; k++)
        if (i_avs_address == ((k < 4) ? `FOS_OFS_INPUT_MAP : `FOS_OFS_INPUT_MAP_HI))
          func_map_d[k] = i_avs_writedata[8*(k%4) +: 8];
    end
  end
  assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !ack_q;
  assign o_avs_readdata    = rdata_q;

  // Offset arithmetic; subtract saturates at zero so the motor never reverses here
  logic [FW-1:0] freq_d, freq_q;
  logic [FW:0]   sum;
  always_comb
  begin
    sum    = {1'b0, i_freq_setting} + {1'b0, offset_frequency_value_q};
    freq_d = i_freq_setting;
    if (offset_apply)
    begin
      if (offset_direction_select_q)
        freq_d = (i_freq_setting > offset_frequency_value_q) ?
                 i_freq_setting - offset_frequency_value_q : '0;
      else
        freq_d = sum[FW] ? '1 : sum[FW-1:0];
    end
  end

  // Effective sources
  fos_src_s src_d, src_q;
  always_comb
  begin
    if (force_q)
      src_d = '{freq_src: `FOS_SRC_TERMINAL, run_src: `FOS_SRC_TERMINAL};
    else
      src_d = '{freq_src: frequency_source_select_q,
                run_src: run_command_source_select_q};
  end

  always_ff @(posedge i_core_clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      state_q <= FOS_RUN;
      force_q <= 1'b0;
      offset_frequency_value_q    <= '0;
      offset_direction_select_q   <= 1'b0;
      frequency_source_select_q   <= `FOS_RST_SRC;
      run_command_source_select_q <= `FOS_RST_SRC;
      for (int k = 0; k < N_IN; k++)
        func_map_q[k] <= '0;
      ack_q   <= 1'b0;
      rdata_q <= '0;
      freq_q  <= '0;
      src_q   <= '0;
    end
    else
    begin
      state_q <= state_d;
      force_q <= force_d;
      offset_frequency_value_q    <= offset_frequency_value_d;
      offset_direction_select_q   <= offset_direction_select_d;
      frequency_source_select_q   <= frequency_source_select_d;
      run_command_source_select_q <= run_command_source_select_d;
      func_map_q <= func_map_d;
      ack_q   <= ack_d;
      rdata_q <= rdata_d;
      freq_q  <= freq_d;
      src_q   <= src_d;
    end
  end
  assign o_freq_out = freq_q;
  assign o_eff_src  = src_q;
  assign o_stop_req = (state_q == FOS_STOPPING);

  // Checks; the sampled rst_n_q in each antecedent but that of chk_no_switch_run skips the release edge, where the
  // output flops still sit in reset and would be compared against live inputs
  chk_force_sources: assert property (@(posedge i_core_clk) disable iff (!rst_n_q)
    rst_n_q && force_q |=> (o_eff_src.freq_src == `FOS_SRC_TERMINAL && o_eff_src.run_src == `FOS_SRC_TERMINAL))
    else $error("forced sources not terminal");
  chk_release_sources: assert property (@(posedge i_core_clk) disable iff (!rst_n_q)
    rst_n_q && !force_q && $stable(frequency_source_select_q)
    |=> o_eff_src.freq_src == $past(frequency_source_select_q))
    else $error("programmed source not restored");
  chk_no_switch_run: assert property (@(posedge i_core_clk) disable iff (!rst_n_q)
    $changed(force_q) |-> $past(state_q) == FOS_SWITCH || !$past(i_motor_running))
    else $error("source switched while running");
  chk_stop_first: assert property (@(posedge i_core_clk) disable iff (!rst_n_q)
    rst_n_q && state_q == FOS_RUN && i_motor_running && terminal_source_force_input != force_q |=> o_stop_req)
    else $error("no stop before switch");
  chk_pass_through: assert property (@(posedge i_core_clk) disable iff (!rst_n_q)
    rst_n_q && !offset_apply |=> o_freq_out == $past(i_freq_setting))
    else $error("frequency altered without offset");
  chk_offset_add: assert property (@(posedge i_core_clk) disable iff (!rst_n_q)
    rst_n_q && offset_apply && !offset_direction_select_q && !sum[FW] |=> o_freq_out == $past(sum[FW-1:0]))
    else $error("offset add wrong");
  chk_offset_sub: assert property (@(posedge i_core_clk) disable iff (!rst_n_q)
    rst_n_q && offset_apply && offset_direction_select_q && i_freq_setting > offset_frequency_value_q
    |=> o_freq_out == $past(i_freq_setting) - $past(offset_frequency_value_q))
    else $error("offset subtract wrong");
  chk_code_decode: assert property (@(posedge i_core_clk) disable iff (!rst_n_q)
    rst_n_q && sync2_q[0] && func_map_q[0] == `FOS_FUNC_OFFSET && !offset_direction_select_q && !sum[FW]
    |=> o_freq_out == $past(sum[FW-1:0]))
    else $error("code 50 input not applied");
endmodule

// ===== hw/fos_defs.svh
// Purpose: Constants for the frequency offset and source force block
// Assumes: Included by bare name from the package and the design
// Notes:   Register map and function codes
`ifndef FOS_DEFS_SVH
`define FOS_DEFS_SVH
`define FOS_OFS_OFFSET_VALUE  4'h0
`define FOS_OFS_OFFSET_DIR    4'h1
`define FOS_OFS_FREQ_SRC      4'h2
`define FOS_OFS_RUN_SRC       4'h3
`define FOS_OFS_INPUT_MAP     4'h4
`define FOS_OFS_STATUS        4'h5
`define FOS_OFS_FREQ_SET      4'h6
`define FOS_OFS_FREQ_OUT      4'h7
`define FOS_OFS_INPUT_MAP_HI  4'h8
`define FOS_FUNC_OFFSET       8'h32
`define FOS_FUNC_FORCE        8'h33
`define FOS_SRC_TERMINAL      8'h01
`define FOS_RST_SRC           8'h02
`endif

// ===== hw/fos_pkg.sv
// Purpose: Types for the frequency offset and source force block
// Assumes: Constants come from fos_defs.svh
// Notes:   Struct carries the effective source pair
`include "fos_defs.svh"
package fos_pkg;
  typedef struct packed {
    logic [7:0] freq_src;
    logic [7:0] run_src;
  } fos_src_s;
  typedef enum logic [1:0] {
    FOS_RUN      = 2'b00,
    FOS_STOPPING = 2'b01,
    FOS_SWITCH   = 2'b10
  } fos_state_e;
endpackage

// ===== verification/fos_ctrl_model.sv
// Purpose: External controller and motor on the far side of the block
// Assumes: Shares the block clock
// Notes:   Motor coasts for a while after a stop request, never at once
`timescale 1ns/1ps
module fos_ctrl_model #(
  parameter int STOP_CYC = 6
) (
  input  wire logic       i_core_clk,
  input  wire logic [4:0] i_term_cmd,
  input  wire logic       i_run_cmd,
  input  wire logic       i_stop_req,
  output logic [4:0]      o_term_in,
  output logic            o_motor_running,
  output logic            o_motor_stopped
);
  int cnt = 0;
  initial o_term_in = 5'h00;
  initial o_motor_running = 1'b0;
  // Terminals lag the controller one cycle; a stop request wins over run
  always @(posedge i_core_clk)
  begin
    o_term_in <= i_term_cmd;
    if (i_stop_req && o_motor_running)
    begin
      cnt <= cnt + 1;
      if (cnt == STOP_CYC)
        o_motor_running <= 1'b0;
    end
    else
    begin
      cnt <= 0;
      if (!i_stop_req)
        o_motor_running <= i_run_cmd;
    end
  end
  assign o_motor_stopped = !o_motor_running;
endmodule

// ===== verification/freq_offset_and_source_force_tb.sv
// Purpose: Self-checking bench for the offset and terminal force block
// Assumes: Master waits for waitrequest low at a rising edge; terminals take a few edges
// Notes:   Input 0 is mapped to offset, input 1 to terminal force
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin num_errors++; \
  $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module freq_offset_and_source_force_tb;
  import fos_pkg::*;
  logic        clk = 0, arst_n = 0, run = 0, rd = 0, wr = 0, wq, stp, mrun, mstop;
  logic [3:0]  adr = 0;
  logic [4:0]  tcmd = 0, tin;
  logic [15:0] setf = 0, fout;
  logic [31:0] wd = 0, rdat, q;
  fos_src_s    src;
  int          num_errors = 0, num_checks = 0, i, n;
  fos_core uut (.i_core_clk(clk), .i_arst_n(arst_n), .i_term_in(tin), .i_freq_setting(setf),
    .i_motor_running(mrun), .i_motor_stopped(mstop), .i_avs_address(adr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wd), .o_avs_readdata(rdat), .o_avs_waitrequest(wq),
    .o_freq_out(fout), .o_eff_src(src), .o_stop_req(stp));
  fos_ctrl_model ctl (.i_core_clk(clk), .i_term_cmd(tcmd), .i_run_cmd(run), .i_stop_req(stp),
    .o_term_in(tin), .o_motor_running(mrun), .o_motor_stopped(mstop));
  // Free-running 40 MHz clock
  initial
  begin
    forever #12.5 clk = ~clk;
  end
  task automatic give_verdict();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge clk);
  endtask
  // One bus access: request stands until waitrequest is sampled low at a rising edge,
  // read data is taken at that edge, and the request is released right after it
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    adr <= a;
    wd  <= d;
    wr  <= w;
    rd  <= !w;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (wq !== 1'b0 && k < 20);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    if (wq !== 1'b0)
    begin
      num_errors++;
      give_verdict();
    end
  endtask
  // Hang guard
  initial
  begin
    tick(20000);
    num_errors++;
    give_verdict();
  end
  initial
  begin
    tick(12);
    arst_n <= 1'b1;
    setf <= 16'h1000;
    tick(4);
    `CHK(src, 16'h0202)
    `CHK(fout, 16'h1000)
    bus(0, 4'h2, 32'h0);
    `CHK(q, 32'h0000_0002)
    bus(1, 4'h0, 32'h0000_0064);
    bus(1, 4'h4, 32'h0000_3332);
    tcmd <= 5'h01;
    tick(6);
    `CHK(fout, 16'h1064)
    bus(1, 4'h1, 32'h0000_0001);
    tick(3);
    `CHK(fout, 16'h0F9C)
    setf <= 16'h0020;
    tick(3);
    `CHK(fout, 16'h0000)
    bus(1, 4'h1, 32'h0);
    setf <= 16'hFFF0;
    tick(3);
    `CHK(fout, 16'hFFFF)
    // Sources 0 to 4 each take the offset alike
    for (i = 0; i < 5; i++)
    begin
      bus(1, 4'h2, i);
      setf <= 16'h0100 * (i + 1);
      tick(3);
      `CHK(fout, 16'(16'h0100 * (i + 1) + 16'h0064))
    end
    tcmd <= 5'h00;
    tick(6);
    `CHK(fout, 16'h0500)
    bus(1, 4'h3, 32'h0000_0003);
    tick(3);
    `CHK(src, 16'h0403)
    tcmd <= 5'h02;
    tick(6);
    `CHK(src, 16'h0101)
    bus(0, 4'h5, 32'h0);
    `CHK(q[3:0], 4'h6)
    tcmd <= 5'h00;
    tick(6);
    `CHK(src, 16'h0403)
    // Force change while running must hold old sources until the motor stops
    run <= 1'b1;
    tick(3);
    tcmd <= 5'h02;
    tick(5);
    `CHK(stp, 1'b1)
    `CHK(src, 16'h0403)
    n = 0;
    while (stp !== 1'b0 && n < 40)
    begin
      tick(1);
      n++;
    end
    `CHK(n < 40, 1'b1)
    tick(4);
    `CHK(src, 16'h0101)
    run <= 1'b0;
    bus(0, 4'h9, 32'h0);
    `CHK(q, 32'h0)
    bus(0, 4'h0, 32'h0);
    `CHK(q, 32'h0000_0064)
    bus(0, 4'h7, 32'h0);
    `CHK(q, 32'h0000_0500)
    bus(0, 4'h6, 32'h0);
    `CHK(q, 32'h0000_0500)
    bus(0, 4'h3, 32'h0);
    `CHK(q, 32'h0000_0003)
    // Fifth input sits in the upper map word
    bus(1, 4'h8, 32'h0000_0032);
    bus(0, 4'h8, 32'h0);
    `CHK(q, 32'h0000_0032)
    tcmd <= 5'h12;
    tick(6);
    `CHK(fout, 16'h0564)
    `CHK(src, 16'h0101)
    // An input with no function code changes nothing; force drops with the motor stopped
    tcmd <= 5'h04;
    tick(6);
    `CHK(fout, 16'h0500)
    `CHK(stp, 1'b0)
    `CHK(src, 16'h0403)
    // Second reset in mid-run: settings and map fall back to their reset values
    arst_n <= 1'b0;
    tick(2);
    `CHK(src, 16'h0000)
    arst_n <= 1'b1;
    tick(4);
    `CHK(src, 16'h0202)
    `CHK(fout, 16'h0500)
    give_verdict();
  end
endmodule
